// file: logic/tlm_bank.sv
// Purpose: One single-cycle memory bank, RAM or ROM
// Assumes: Read data registered, valid the cycle after the strobe
// Notes:   ROM ignores writes and reads as its init contents
`timescale 1ns/1ps
module tlm_bank #(
    parameter int AW       = 11,
    parameter bit READONLY = 1'b0
) (
    // Clock
    input wire logic clk,
    // Port
    tlm_mem_if.mem   port
);
    // ======================================================================
    // Storage
    // Contents start at zero; a ROM bank would be mask-programmed instead
    logic [31:0] mem_q [2**AW] = '{default: 32'h0000_0000};  // Word array
    logic [31:0] rdata_q;         // Output register
    logic [31:0] rdata_d;         // Next output

    // Read path
    always_comb begin
        rdata_d = port.en ? mem_q[port.addr] : rdata_q;
    end

    // Write and register
    always_ff @(posedge clk) begin
        rdata_q <= rdata_d;
        if (port.en && port.we && !READONLY) begin
            for (int b = 0; b < 4; b++) begin
                if (port.be[b]) begin
                    mem_q[port.addr][8*b +: 8] <= port.wdata[8*b +: 8];
                end
            end
        end
    end

    assign port.rdata = rdata_q;
endmodule

// file: logic/tlm_cfg.svh
// Purpose: Constants for the local memory decode and configuration block
// Assumes: Included by bare name from design files
// Notes:   Offsets are byte addresses on the core local-memory ports
`ifndef TLM_CFG_SVH
`define TLM_CFG_SVH

// ==========================================================================
// Address windows
`define TLM_I_WIN_LO      32'h0000_0000
`define TLM_I_WIN_HI      32'h0000_5FFF
`define TLM_D_WIN_LO      32'h0000_8000
`define TLM_D_WIN_HI      32'h0000_DFFF
`define TLM_BANK_BITS     13
`define TLM_BANK_SEL_LSB  13
`define TLM_SEL_LOW       2'h0
`define TLM_SEL_HIGH      2'h1
`define TLM_SEL_ROM       2'h2
`define TLM_SEL_RSVD      2'h3

// ==========================================================================
// Coprocessor selectors
`define TLM_CRN_ID        4'h0
`define TLM_CRM_ID        4'h0
`define TLM_OP2_STATUS    3'h2
`define TLM_CRN_REGION    4'h9
`define TLM_OP2_DATA      3'h0
`define TLM_OP2_INSTR     3'h1
`define TLM_OP1_SYS       3'h0

// ==========================================================================
// Register fields
`define TLM_STAT_D_BIT    16
`define TLM_STAT_I_BIT    0
`define TLM_BASE_LSB      12
`define TLM_SIZE_LSB      2
`define TLM_ENB_BIT       0
`define TLM_SIZE_I        4'h5
`define TLM_SIZE_D        4'h6
`define TLM_MODE_USR      5'h10
`define TLM_RESET_BASE    20'h0_0000

`endif

// file: logic/tlm_mem_if.sv
// Purpose: Bundle between the decode top and one memory bank
// Assumes: Single clock
// Notes:   Word-wide access with byte enables
`timescale 1ns/1ps
interface tlm_mem_if #(parameter int AW = 11);
    logic          en;     // Access strobe
    logic          we;     // Write strobe
    logic [3:0]    be;     // Byte enables
    logic [AW-1:0] addr;   // Word address
    logic [31:0]   wdata;  // Write data
    logic [31:0]   rdata;  // Registered read data
    modport ctl (output en, we, be, addr, wdata, input rdata);
    modport mem (input en, we, be, addr, wdata, output rdata);
endinterface

// file: logic/tlm_pkg.sv
// Purpose: Types for the local memory decode and configuration block
// Assumes: Nothing
// Notes:   Constants live in the header, types here
package tlm_pkg;
    // ======================================================================
    // Bank selection
    typedef enum logic [1:0] {
        TLM_BANK_LOW,
        TLM_BANK_HIGH,
        TLM_BANK_ROM,
        TLM_BANK_NONE
    } tlm_bank_t;
endpackage

// file: logic/tlm_top.sv
// Purpose: Local memory window decode plus status and region setup registers
// Assumes: Core ports are on clk; privilege mode comes from the core
// Notes:   Read data and hit flags return one cycle after the request
//
// What this block does
// [RULE1] Instruction window spans 0x0000 to 0x5FFF
// [RULE2] Data window spans 0x8000 to 0xDFFF
// [RULE3] Low RAM bank at 0x0000 and 0x8000
// [RULE4] High RAM bank at 0x2000 and 0xA000
// [RULE5] ROM bank at 0x4000 and 0xC000
// [RULE6] 8 KB above each window (0x6000, 0xE000) unbacked
// [RULE7] Config access only by privileged coprocessor ops
// [RULE8] Status read: c0, op1 0, crm c0, op2 2
// [RULE9] Status bit 16 shows data memory present
// [RULE10] Status bit 0 shows instruction memory present
// [RULE11] Bits 31..12 hold base address
// [RULE12] Bits 5..2 size code, 11..6 zero
// [RULE13] Region bit 1 always reads zero
// [RULE14] Bit 0 enables window decoding
// [RULE15] Region select c9, op2 0 data, 1 instr
// [RULE16] Instruction size code fixed at 5
// [RULE17] Data size code fixed at 6
// [RULE18] Software programs base 0x00000 and 0x00008
`timescale 1ns/1ps
`include "tlm_cfg.svh"
module tlm_top #(
    parameter int AW = 11   // Word address bits per 8 KB bank
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // Instruction local port
    input  wire logic        i_req,
    input  wire logic [31:0] i_addr,
    output logic             i_hit,
    output logic [31:0]      i_rdata,
    // Data local port
    input  wire logic        d_req,
    input  wire logic        d_we,
    input  wire logic [3:0]  d_be,
    input  wire logic [31:0] d_addr,
    input  wire logic [31:0] d_wdata,
    output logic             d_hit,
    output logic [31:0]      d_rdata,
    // Coprocessor access
    input  wire logic        cp_rd,
    input  wire logic        cp_wr,
    input  wire logic [4:0]  cp_mode,
    input  wire logic [2:0]  cp_op1,
    input  wire logic [3:0]  cp_crn,
    input  wire logic [3:0]  cp_crm,
    input  wire logic [2:0]  cp_op2,
    input  wire logic [31:0] cp_wdata,
    output logic             cp_ack,
    output logic [31:0]      cp_rdata
);
    // Elaboration guard; each bank must cover exactly 8 KB of bytes
    if (AW + 2 != `TLM_BANK_BITS) begin : g_bad_aw
        $error("AW must cover exactly 8 KB");
    end

    // ======================================================================
    // Decode helpers
    // Bank from address bits 14..13 inside a window
    function automatic tlm_pkg::tlm_bank_t bank_of(input logic [31:0] a);
        case (a[`TLM_BANK_SEL_LSB +: 2])
            `TLM_SEL_LOW:  bank_of = tlm_pkg::TLM_BANK_LOW;
            `TLM_SEL_HIGH: bank_of = tlm_pkg::TLM_BANK_HIGH;
            `TLM_SEL_ROM:  bank_of = tlm_pkg::TLM_BANK_ROM;
            default:       bank_of = tlm_pkg::TLM_BANK_NONE;
        endcase
    endfunction

    // Window hit check with enable and programmed base
    function automatic logic in_win(input logic [31:0] a, input logic [31:0] lo,
                                    input logic [31:0] hi, input logic [19:0] base,
                                    input logic en);
        // Base shifted up by 12; its bits 31..15 are base bits 19..3
        in_win = en && a >= lo && a <= hi && a[31:15] == base[19:3];
    endfunction

    // ======================================================================
    // Region setup state
    logic [19:0] i_base_q, i_base_d;   // Instruction base field
    logic [19:0] d_base_q, d_base_d;   // Data base field
    logic        i_en_q, i_en_d;       // Instruction window enable
    logic        d_en_q, d_en_d;       // Data window enable
    logic        cp_ack_q, cp_ack_d;   // Access accepted
    logic [31:0] cp_rdata_q, cp_rdata_d;
    logic        priv;                 // Core is in privileged mode
    logic        sel_stat, sel_ireg, sel_dreg;

    // Selectors; user mode is shut out entirely
    assign priv     = cp_mode != `TLM_MODE_USR;                   // RULE7
    assign sel_stat = cp_op1 == `TLM_OP1_SYS && cp_crn == `TLM_CRN_ID
                   && cp_crm == `TLM_CRM_ID && cp_op2 == `TLM_OP2_STATUS; // RULE8
    assign sel_dreg = cp_op1 == `TLM_OP1_SYS && cp_crn == `TLM_CRN_REGION
                   && cp_op2 == `TLM_OP2_DATA;                    // RULE15
    assign sel_ireg = cp_op1 == `TLM_OP1_SYS && cp_crn == `TLM_CRN_REGION
                   && cp_op2 == `TLM_OP2_INSTR;                   // RULE15

    // Register next state; size codes never take write data
    always_comb begin
        i_base_d   = i_base_q;
        d_base_d   = d_base_q;
        i_en_d     = i_en_q;
        d_en_d     = d_en_q;
        cp_ack_d   = (cp_rd || cp_wr) && priv && (sel_stat || sel_ireg || sel_dreg); // RULE7
        cp_rdata_d = cp_rdata_q;
        if (cp_wr && priv && sel_ireg) begin
            i_base_d = cp_wdata[31:`TLM_BASE_LSB];                // RULE11
            i_en_d   = cp_wdata[`TLM_ENB_BIT];                    // RULE14
        end
        if (cp_wr && priv && sel_dreg) begin
            d_base_d = cp_wdata[31:`TLM_BASE_LSB];                // RULE11
            d_en_d   = cp_wdata[`TLM_ENB_BIT];                    // RULE14
        end
        if (cp_rd && priv) begin
            if (sel_stat) begin
                cp_rdata_d = 32'h0000_0000;                       // RULE9 RULE10
                cp_rdata_d[`TLM_STAT_D_BIT] = 1'b1;               // RULE9
                cp_rdata_d[`TLM_STAT_I_BIT] = 1'b1;               // RULE10
            end else if (sel_ireg) begin
                // Bits 11..6 and bit 1 stay zero
                cp_rdata_d = {i_base_q, 6'h00, `TLM_SIZE_I, 1'b0, i_en_q}; // RULE12 RULE13 RULE16
            end else if (sel_dreg) begin
                cp_rdata_d = {d_base_q, 6'h00, `TLM_SIZE_D, 1'b0, d_en_q}; // RULE12 RULE13 RULE17
            end
            // Unknown selector is refused; last result stays put
        end
    end

    // Register the setup state; windows start disabled
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            i_base_q   <= `TLM_RESET_BASE;
            d_base_q   <= `TLM_RESET_BASE;
            i_en_q     <= 1'b0;
            d_en_q     <= 1'b0;
            cp_ack_q   <= 1'b0;
            cp_rdata_q <= 32'h0000_0000;
        end else begin
            i_base_q   <= i_base_d;
            d_base_q   <= d_base_d;
            i_en_q     <= i_en_d;
            d_en_q     <= d_en_d;
            cp_ack_q   <= cp_ack_d;
            cp_rdata_q <= cp_rdata_d;
        end
    end
    assign cp_ack   = cp_ack_q;
    assign cp_rdata = cp_rdata_q;

    // ======================================================================
    // Port decode
    logic               i_in, d_in;      // Window hits
    tlm_pkg::tlm_bank_t i_bank, d_bank;  // Target banks
    logic               i_ok, d_ok;      // Hit on a backed bank
    logic [1:0]         i_sel_q, i_sel_d, d_sel_q, d_sel_d;
    logic               i_hit_q, i_hit_d, d_hit_q, d_hit_d;

    // Base compare keeps software programming meaningful beside fixed ranges
    assign i_in   = in_win(i_addr, `TLM_I_WIN_LO, `TLM_I_WIN_HI, i_base_q, i_en_q); // RULE1 RULE14
    assign d_in   = in_win(d_addr, `TLM_D_WIN_LO, `TLM_D_WIN_HI, d_base_q, d_en_q); // RULE2 RULE14
    assign i_bank = bank_of(i_addr);     // RULE3 RULE4 RULE5
    assign d_bank = bank_of(d_addr);     // RULE3 RULE4 RULE5
    assign i_ok   = i_req && i_in && i_bank != tlm_pkg::TLM_BANK_NONE; // RULE6
    assign d_ok   = d_req && d_in && d_bank != tlm_pkg::TLM_BANK_NONE; // RULE6

    // Bank interfaces; data port wins a clash on a shared bank
    tlm_mem_if #(.AW(AW)) bk [3] ();
    logic [2:0] i_use, d_use;

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_bank
            assign d_use[g]    = d_ok && d_bank == tlm_pkg::tlm_bank_t'(g);
            assign i_use[g]    = i_ok && i_bank == tlm_pkg::tlm_bank_t'(g) && !d_use[g];
            assign bk[g].en    = d_use[g] || i_use[g];
            assign bk[g].we    = d_use[g] && d_we;
            assign bk[g].be    = d_be;
            assign bk[g].addr  = d_use[g] ? d_addr[2 +: AW] : i_addr[2 +: AW];
            assign bk[g].wdata = d_wdata;
            tlm_bank #(.AW(AW), .READONLY(g == 2)) u_bank (
                .clk  (clk),
                .port (bk[g])
            );
        end
    endgenerate

    // Hit flags; an instruction fetch stalled by a clash reports a miss
    always_comb begin
        i_hit_d = i_ok && !d_use[i_bank[1:0]];
        d_hit_d = d_ok;
        i_sel_d = i_bank[1:0];
        d_sel_d = d_bank[1:0];
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            i_hit_q <= 1'b0;
            d_hit_q <= 1'b0;
            i_sel_q <= `TLM_SEL_LOW;
            d_sel_q <= `TLM_SEL_LOW;
        end else begin
            i_hit_q <= i_hit_d;
            d_hit_q <= d_hit_d;
            i_sel_q <= i_sel_d;
            d_sel_q <= d_sel_d;
        end
    end

    assign i_hit = i_hit_q;
    assign d_hit = d_hit_q;

    // Read data mux behind registered bank outputs
    logic [31:0] rd_w [3];
    for (g = 0; g < 3; g++) begin : g_rd
        assign rd_w[g] = bk[g].rdata;
    end
    assign i_rdata = (i_sel_q == `TLM_SEL_RSVD) ? 32'h0000_0000 : rd_w[i_sel_q];
    assign d_rdata = (d_sel_q == `TLM_SEL_RSVD) ? 32'h0000_0000 : rd_w[d_sel_q];

    // ======================================================================
    // Checks
    a_user_blocked: assert property (@(posedge clk) disable iff (!resetn)
        cp_mode == `TLM_MODE_USR |=> !cp_ack) else $error("user mode access acked"); // RULE7
    a_status_value: assert property (@(posedge clk) disable iff (!resetn)
        cp_rd && priv && sel_stat |=> cp_rdata == 32'h0001_0001)
        else $error("status value wrong"); // RULE9
    a_isize_fixed: assert property (@(posedge clk) disable iff (!resetn)
        cp_rd && priv && sel_ireg |=> cp_rdata[5:2] == 4'h5 && cp_rdata[11:6] == 6'h00)
        else $error("instr size wrong"); // RULE16
    a_dsize_fixed: assert property (@(posedge clk) disable iff (!resetn)
        cp_rd && priv && sel_dreg |=> cp_rdata[5:2] == 4'h6 && !cp_rdata[1])
        else $error("data size wrong"); // RULE17
    a_disabled_miss: assert property (@(posedge clk) disable iff (!resetn)
        !i_en_q |=> !i_hit) else $error("hit while disabled"); // RULE14
    a_rsvd_miss: assert property (@(posedge clk) disable iff (!resetn)
        d_addr[15:13] == 3'h7 |=> !d_hit) else $error("reserved data hit"); // RULE6
    a_iwin_limit: assert property (@(posedge clk) disable iff (!resetn)
        i_addr > 32'h0000_5FFF |=> !i_hit) else $error("instr hit outside"); // RULE1
    a_dwin_limit: assert property (@(posedge clk) disable iff (!resetn)
        d_addr < 32'h0000_8000 |=> !d_hit) else $error("data hit outside"); // RULE2
endmodule

// file: test/tb_top.sv
// Purpose: Self-checking bench for the local memory decode block
// Assumes: Core model drives every request on the falling edge
// Notes:   Model pauses a cycle between requests
`timescale 1ns/1ps
`include "tlm_cfg.svh"
module tb_top;
    // ======
    // Wiring
    logic        clk, resetn, i_req, i_hit, d_req, d_we, d_hit, cp_rd, cp_wr, cp_ack;
    logic [31:0] i_addr, i_rdata, d_addr, d_wdata, d_rdata, cp_wdata, cp_rdata;
    logic [4:0]  cp_mode;
    logic [3:0]  d_be, cp_crn, cp_crm;
    logic [2:0]  cp_op1, cp_op2;
    int          errors, comparisons;
    localparam logic [4:0]  SYS = 5'h1F;           // Privileged system mode
    localparam logic [4:0]  USR = `TLM_MODE_USR;
    localparam logic        N   = 1'h0;
    localparam logic        Y   = 1'h1;
    localparam logic [31:0] Z   = 32'h0000_0000;

    tlm_top        tlm_top_i (.*);
    tlm_core_model tlm_core_model_i (.*);

    // Clock
    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Coprocessor op with expected acceptance and read value
    task automatic cpx(input logic w, input logic [4:0] m, input logic [2:0] o1,
                       input logic [3:0] n, input logic [2:0] o2, input logic [31:0] wd,
                       input logic ea, input logic [31:0] er, input logic [3:0] cm = 4'h0);
        tlm_core_model_i.cp(w, m, o1, n, o2, wd, cm);
        chk(tlm_core_model_i.ack, {31'h0, ea});
        if (ea && !w)
            chk(tlm_core_model_i.crd, er);
    endtask

    // Memory access; data compared only where a hit is expected
    task automatic mx(input logic ir, input logic [31:0] ia, input logic dr, dw,
                      input logic [3:0] be, input logic [31:0] da, wd,
                      input logic eih, edh, input logic [31:0] eir, edr);
        tlm_core_model_i.acc(ir, ia, dr, dw, be, da, wd);
        if (ir)
            chk(tlm_core_model_i.ih, {31'h0, eih});
        if (ir && eih)
            chk(tlm_core_model_i.ird, eir);
        if (dr)
            chk(tlm_core_model_i.dh, {31'h0, edh});
        if (dr && edh && !dw)
            chk(tlm_core_model_i.drd, edr);
    endtask

    // Register reads, refusals, fixed fields, then windows enabled
    task automatic t_cfg();
        cpx(N, SYS, 3'h0, 4'h0, 3'h2, Z, Y, 32'h0001_0001);
        cpx(N, USR, 3'h0, 4'h0, 3'h2, Z, N, Z);
        cpx(N, SYS, 3'h1, 4'h0, 3'h2, Z, N, Z);
        cpx(N, SYS, 3'h0, 4'h0, 3'h2, Z, N, Z, 4'h1);
        cpx(N, SYS, 3'h0, 4'h9, 3'h0, Z, Y, 32'h0000_0018);
        cpx(N, SYS, 3'h0, 4'h9, 3'h1, Z, Y, 32'h0000_0014);
        mx(N, Z, Y, N, 4'hF, 32'h0000_8000, Z, N, N, Z, Z);
        cpx(Y, USR, 3'h0, 4'h9, 3'h0, 32'h0000_8001, N, Z);
        mx(N, Z, Y, N, 4'hF, 32'h0000_8000, Z, N, N, Z, Z);
        cpx(Y, SYS, 3'h0, 4'h9, 3'h0, 32'h0000_8FFF, Y, Z);
        cpx(N, SYS, 3'h0, 4'h9, 3'h0, Z, Y, 32'h0000_8019);
        cpx(Y, SYS, 3'h0, 4'h9, 3'h1, 32'h0000_0FC3, Y, Z);
        cpx(N, SYS, 3'h0, 4'h9, 3'h1, Z, Y, 32'h0000_0015);
        cpx(N, SYS, 3'h0, 4'h9, 3'h1, Z, Y, 32'h0000_0015, 4'h1);
    endtask

    // Each bank at its second and last words, seen from both ports
    task automatic t_map();
        logic [31:0] off, v;
        for (int b = 0; b < 3; b++) begin
            for (int k = 0; k < 2; k++) begin
                off = (b * 32'h0000_2000) + (k ? 32'h0000_1FFC : 32'h0000_0004);
                v = (b == 2) ? Z : 32'h5A00_0000 + off;
                mx(N, Z, Y, Y, 4'hF, 32'h0000_8000 + off, 32'h5A00_0000 + off,
                   N, Y, Z, Z);
                mx(Y, off, N, N, 4'hF, Z, Z, Y, N, v, Z);
                mx(N, Z, Y, N, 4'hF, 32'h0000_8000 + off, Z, N, Y, Z, v);
            end
        end
        mx(Y, 32'h0000_6000, Y, N, 4'hF, 32'h0000_E000, Z, N, N, Z, Z);
        mx(Y, 32'h0000_8000, Y, N, 4'hF, Z, Z, N, N, Z, Z);
        mx(N, Z, Y, Y, 4'hF, 32'h0000_A008, 32'h1122_3344, N, Y, Z, Z);
        mx(N, Z, Y, Y, 4'h3, 32'h0000_A008, 32'hAABB_CCDD, N, Y, Z, Z);
        mx(Y, 32'h0000_2008, N, N, 4'hF, Z, Z, Y, N, 32'h1122_CCDD, Z);
    endtask

    // Both ports at once, same bank then different banks, then disable
    task automatic t_both();
        mx(Y, 32'h0000_0010, Y, Y, 4'hF, 32'h0000_8010, 32'h1234_5678,
           N, Y, Z, Z);
        mx(Y, 32'h0000_2004, Y, N, 4'hF, 32'h0000_8010, Z,
           Y, Y, 32'h5A00_2004, 32'h1234_5678);
        cpx(Y, SYS, 3'h0, 4'h9, 3'h0, 32'h0000_8000, Y, Z);
        mx(Y, 32'h0000_0010, Y, N, 4'hF, 32'h0000_8010, Z,
           Y, N, 32'h1234_5678, Z);
    endtask

    // Mid-run reset: windows fall back to disabled, base to zero
    task automatic t_rst();
        @(negedge clk);
        resetn = 1'h0;
        repeat (2) @(negedge clk);
        resetn = 1'h1;
        cpx(N, SYS, 3'h0, 4'h9, 3'h0, Z, Y, 32'h0000_0018);
        mx(N, Z, Y, N, 4'hF, 32'h0000_8000, Z, N, N, Z, Z);
    endtask

    task automatic test_done();
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Reset, then the scenarios in order
    initial begin
        errors = 0;
        comparisons = 0;
        resetn = 1'h0;
        repeat (20) @(negedge clk);
        resetn = 1'h1;
        t_cfg();
        t_map();
        t_both();
        t_rst();
        test_done();
    end

    // Run needs well under 200 cycles; this bound only catches a hang
    initial begin
        #20000;
        errors++;
        test_done();
    end
endmodule

// file: test/tlm_core_model.sv
// Purpose: Core-side model of the local memory and coprocessor ports
// Assumes: Requests launch on the falling edge, one at a time
// Notes:   Released lines carry inverted values so stale data never matches
`timescale 1ns/1ps
module tlm_core_model (
    // Clock
    input  wire logic        clk,
    // Memory ports
    output logic             i_req,
    output logic [31:0]      i_addr,
    input  wire logic        i_hit,
    input  wire logic [31:0] i_rdata,
    output logic             d_req,
    output logic             d_we,
    output logic [3:0]       d_be,
    output logic [31:0]      d_addr,
    output logic [31:0]      d_wdata,
    input  wire logic        d_hit,
    input  wire logic [31:0] d_rdata,
    // Coprocessor port
    output logic             cp_rd,
    output logic             cp_wr,
    output logic [4:0]       cp_mode,
    output logic [2:0]       cp_op1,
    output logic [3:0]       cp_crn,
    output logic [3:0]       cp_crm,
    output logic [2:0]       cp_op2,
    output logic [31:0]      cp_wdata,
    input  wire logic        cp_ack,
    input  wire logic [31:0] cp_rdata
);
    // ======
    // Captured answers
    logic [31:0] ih, ird, dh, drd, ack, crd;

    // Idle at time zero
    initial begin
        {i_req, i_addr, d_req, d_we, d_be, d_addr, d_wdata} = '0;
        {cp_rd, cp_wr, cp_mode, cp_op1, cp_crn, cp_crm, cp_op2, cp_wdata} = '0;
    end

    // One coprocessor op, answer sampled after the taking edge
    task automatic cp(input logic w, input logic [4:0] m, input logic [2:0] o1,
                      input logic [3:0] n, input logic [2:0] o2, input logic [31:0] wd,
                      input logic [3:0] cm = 4'h0);
        @(negedge clk);
        {cp_rd, cp_wr, cp_mode, cp_op1} <= {!w, w, m, o1};
        {cp_crn, cp_op2, cp_wdata} <= {n, o2, wd};
        cp_crm <= cm;
        @(negedge clk);
        ack = {31'h0, cp_ack};
        crd = cp_rdata;
        {cp_rd, cp_wr, cp_wdata, cp_crn} <= {2'h0, ~wd, ~n};
    endtask

    // One access on either or both memory ports
    task automatic acc(input logic ir, input logic [31:0] ia, input logic dr, dw,
                       input logic [3:0] be, input logic [31:0] da, wd);
        @(negedge clk);
        {i_req, i_addr} <= {ir, ia};
        {d_req, d_we, d_be, d_addr, d_wdata} <= {dr, dw, be, da, wd};
        @(negedge clk);
        ih = {31'h0, i_hit};
        ird = i_rdata;
        dh = {31'h0, d_hit};
        drd = d_rdata;
        {i_req, i_addr, d_req, d_addr, d_wdata} <= {1'h0, ~ia, 1'h0, ~da, ~wd};
    endtask
endmodule
